// *** src/pm_seq_pkg.sv ***
package pm_seq_pkg;

   // clock and timing
   localparam int CLK_MHZ = 250;
   localparam int TR_DEL_US = 900;
   localparam int TR_DEL_CYC_DEF = TR_DEL_US * CLK_MHZ;
   localparam int TR_CNT_W = 18;
   localparam int IRQ_PULSE_NS = 100;
   localparam int CLK_NS = 4;
   localparam int IRQ_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int IRQ_CNT_W = 5;

   // synchronised pin vector layout
   localparam int PIN_W = 8;
   localparam int P_SCS = 0;
   localparam int P_EDGE = 1;
   localparam int P_LEVEL = 2;
   localparam int P_CUR = 3;
   localparam int P_SUP = 4;
   localparam int P_SEQ = 5;
   localparam int P_BOOST = 6;
   localparam int P_VLOW = 7;

   // wake source flag layout
   localparam int WAKE_W = 5;
   localparam int W_EDGE = 0;
   localparam int W_LEVEL = 1;
   localparam int W_CUR = 2;
   localparam int W_SPI = 3;
   localparam int W_TIMER = 4;

   typedef enum logic [2:0] {
      ST_POWERDOWN = 3'b000,
      ST_INIT      = 3'b001,
      ST_NORMAL    = 3'b010,
      ST_TO_SLEEP  = 3'b011,
      ST_SLEEP     = 3'b100,
      ST_STANDBY   = 3'b101,
      ST_WAKE      = 3'b110,
      ST_FAILSAFE  = 3'b111
   } pm_state_e;

   typedef enum logic [2:0] {
      CMD_NOP        = 3'b000,
      CMD_GO_NORMAL  = 3'b001,
      CMD_GO_SLEEP   = 3'b010,
      CMD_GO_STANDBY = 3'b011,
      CMD_RESUME     = 3'b100,
      CMD_SET_CFG    = 3'b101
   } pm_cmd_e;

   // command data byte, msb first
   typedef struct packed {
      logic wtimer;
      logic err;
      logic hb;
      logic wdog;
      logic tracker;
      logic ref_en;
      logic comm;
      logic standby;
   } cfg_s;

   localparam logic [7:0] CFG_RESET = 8'h70;

endpackage

// *** src/pm_event_if.sv ***
interface pm_event_if;
   import pm_seq_pkg::*;
   logic [PIN_W-1:0] lvl;
   logic [PIN_W-1:0] rise;
   logic [WAKE_W-1:0] cause;
   logic take;
   logic clr;
   logic [WAKE_W-1:0] flags;

   modport syncer (output lvl, output rise);
   modport fsm (input lvl, input rise, input flags, output cause,
      output take, output clr);
   modport recorder (input cause, input take, input clr, output flags);
endinterface

// *** src/pin_sync.sv ***
module pin_sync
   import pm_seq_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // raw pins
   input wire logic [pm_seq_pkg::PIN_W-1:0] pins,
   // synchronised levels and edges
   pm_event_if.syncer ev
);
   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] prev;
   } sync_s;

   // select idles high; a zero reset would fake a rise on release
   localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(1) << P_SCS;

   sync_s cur_reg;
   sync_s cur_next;

   always_comb begin
      cur_next = cur_reg;
      cur_next.s1 = pins;
      cur_next.s2 = cur_reg.s1;
      cur_next.prev = cur_reg.s2;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_reg <= {PIN_IDLE, PIN_IDLE, PIN_IDLE};
      end else begin
         cur_reg <= cur_next;
      end
   end

   // edges only from second stage, never the metastable first one
   for (genvar i = 0; i < PIN_W; i++) begin : g_edge
      assign ev.lvl[i] = cur_reg.s2[i];
      assign ev.rise[i] = cur_reg.s2[i] & ~cur_reg.prev[i];
   end
endmodule // pin_sync

// *** src/wake_recorder.sv ***
module wake_recorder
   import pm_seq_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // events from the sequencer
   pm_event_if.recorder ev
);
   typedef struct packed {
      logic [WAKE_W-1:0] flags;
   } rec_s;

   rec_s cur_reg;
   rec_s cur_next;

   always_comb begin
      cur_next = cur_reg;
      if (ev.clr) begin
         cur_next.flags = '0;
      end
      // a new cause in the clear cycle survives
      if (ev.take) begin
         cur_next.flags = cur_next.flags | ev.cause;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign ev.flags = cur_reg.flags;
endmodule // wake_recorder

// *** src/pm_sequencer.sv ***
// Summary of operation
// - wake from sleep on current, pin, resume
// - selftest in normal moves to wake
// - wake entry: interrupt, monitors from normal
// - wake entry restores normal supply enables
// - both safe-state outputs low in wake
// - reset output stays high in wake
// - wake-up timer off in wake
// - standby supply settable by command in wake
// - comm, ref, tracker restored then settable
// - monitors reconfigurable by command in wake
// - pre-converter and mcu supply on in wake
// - boost only when strapped and input low
// - core supply from strap at sequencing
// - severe failure: failsafe, everything off
// - failsafe: reset low, safe-state low
// - commands act on select rising edge
// - powerdown to init on power clear
// - wake accepts sleep and standby requests
// - init to normal on command, outputs together
// - record wake source, interrupt on wake
module pm_sequencer
   import pm_seq_pkg::*;
#(
   parameter int TR_DEL_CYCLES = pm_seq_pkg::TR_DEL_CYC_DEF
) (
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rst,
   // pins from outside the clock domain
   input wire logic spi_select_n,
   input wire logic edge_wake_in,
   input wire logic level_rouse_in,
   input wire logic mcu_current_threshold,
   input wire logic supply_rise_threshold,
   input wire logic core_seq_pin,
   input wire logic boost_select_pin,
   input wire logic vin_low,
   // decoded command from the spi receiver
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [7:0] cmd_data,
   // on-chip services
   input wire logic monitors_serviced,
   input wire logic analog_selftest,
   input wire logic wake_timer_done,
   input wire logic severe_fail,
   input wire logic wake_flags_clr,
   // supply enables
   output logic standby_supply_en,
   output logic mcu_supply_en,
   output logic comm_supply_en,
   output logic ref_supply_en,
   output logic sensor_tracker_en,
   output logic pre_converter_en,
   output logic boost_en,
   output logic core_supply_en,
   // supervision enables
   output logic wake_timer_en,
   output logic window_watchdog_en,
   output logic heartbeat_watchdog_en,
   output logic fault_monitor_en,
   // reset, safe state, interrupt, status
   output logic sys_reset_pin_n,
   output logic safe_state_control,
   output logic safe_state_out_a,
   output logic safe_state_out_b,
   output logic irq,
   output logic [pm_seq_pkg::WAKE_W-1:0] wake_source_flags,
   output pm_seq_pkg::pm_state_e op_state
);
   import pm_seq_pkg::*;

   typedef struct packed {
      logic stby;
      logic mcu;
      logic comm;
      logic ref_en;
      logic trk;
      logic pre;
      logic boost;
      logic core;
      logic wtim;
      logic wdog;
      logic hb;
      logic err;
      logic rst_n;
      logic safe;
      logic irq;
   } out_s;

   typedef struct packed {
      pm_state_e st;
      cfg_s live;
      cfg_s saved;
      cfg_s slp;
      logic cur_mon;
      logic core_strap;
      logic boost_strap;
      logic [TR_CNT_W-1:0] cnt;
      logic [IRQ_CNT_W-1:0] irq_cnt;
      logic take;
      logic [WAKE_W-1:0] cause;
      logic clr;
      out_s o;
   } seq_s;

   localparam logic [TR_CNT_W-1:0] TR_LAST =
      TR_CNT_W'(TR_DEL_CYCLES - 1);
   localparam logic [IRQ_CNT_W-1:0] IRQ_LOAD = IRQ_CNT_W'(IRQ_CYC);

   seq_s cur_reg;
   seq_s cur_next;
   pm_event_if ev ();

   pin_sync u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pins({vin_low, boost_select_pin, core_seq_pin,
         supply_rise_threshold, mcu_current_threshold, level_rouse_in,
         edge_wake_in, spi_select_n}),
      .ev(ev)
   );

   wake_recorder u_rec (
      .core_clk(core_clk),
      .rst(rst),
      .ev(ev)
   );

   assign ev.take = cur_reg.take;
   assign ev.cause = cur_reg.cause;
   assign ev.clr = cur_reg.clr;

   always_comb begin
      logic go;
      logic wake_now;
      logic wake_pin;
      logic [WAKE_W-1:0] wcause;
      logic up;
      logic sel_live;
      logic sel_slp;
      cfg_s c;
      pm_cmd_e cmd;
      go = ev.rise[P_SCS] & cmd_valid;
      cmd = pm_cmd_e'(cmd_code);
      up = 1'b0;
      sel_live = 1'b0;
      sel_slp = 1'b0;
      c = '0;
      wake_now = 1'b0;
      wcause = '0;
      wake_pin = ev.rise[P_EDGE] | ev.lvl[P_LEVEL];
      cur_next = cur_reg;
      cur_next.take = 1'b0;
      cur_next.cause = '0;
      cur_next.clr = wake_flags_clr;
      if (cur_reg.irq_cnt != '0) begin
         cur_next.irq_cnt = cur_reg.irq_cnt - IRQ_CNT_W'(1);
      end
      case (cur_reg.st)
         ST_POWERDOWN: begin
            if (ev.lvl[P_SUP]) begin
               cur_next.st = ST_INIT;
               cur_next.live = cfg_s'(CFG_RESET);
               cur_next.core_strap = ev.lvl[P_SEQ];
               cur_next.boost_strap = ev.lvl[P_BOOST];
            end
         end
         ST_INIT: begin
            if (go && cmd == CMD_SET_CFG) begin
               cur_next.live = cfg_s'(cmd_data);
            end
            // host must have serviced monitors and waited first
            if (go && cmd == CMD_GO_NORMAL && monitors_serviced) begin
               cur_next.st = ST_NORMAL;
            end
         end
         ST_NORMAL, ST_WAKE: begin
            if (go && cmd == CMD_SET_CFG) begin
               cur_next.live = cfg_s'(cmd_data);
            end
            if (go && cmd == CMD_GO_SLEEP) begin
               if (cur_reg.st == ST_NORMAL) begin
                  cur_next.saved = cur_reg.live;
               end
               cur_next.slp = cfg_s'(cmd_data);
               cur_next.cur_mon = cmd_data[7];
               cur_next.cnt = '0;
               cur_next.st = ST_TO_SLEEP;
            end
            if (go && cmd == CMD_GO_STANDBY) begin
               if (cur_reg.st == ST_NORMAL) begin
                  cur_next.saved = cur_reg.live;
               end
               cur_next.st = ST_STANDBY;
            end
            if (cur_reg.st == ST_WAKE && go && cmd == CMD_GO_NORMAL &&
               monitors_serviced) begin
               cur_next.st = ST_NORMAL;
            end
            if (cur_reg.st == ST_NORMAL && analog_selftest &&
               !(go && cmd != CMD_NOP)) begin
               cur_next.saved = cur_reg.live;
               wake_now = 1'b1;
            end
         end
         ST_TO_SLEEP: begin
            cur_next.cnt = cur_reg.cnt + TR_CNT_W'(1);
            wcause[W_EDGE] = ev.rise[P_EDGE];
            wcause[W_LEVEL] = ev.lvl[P_LEVEL];
            wcause[W_SPI] = go && cmd == CMD_RESUME;
            if (cur_reg.cnt >= TR_LAST) begin
               // current still high at expiry keeps the part awake
               wcause[W_CUR] = cur_reg.cur_mon & ev.lvl[P_CUR];
               cur_next.st = ST_SLEEP;
            end
            wake_now = |wcause;
         end
         ST_SLEEP: begin
            wcause[W_EDGE] = ev.rise[P_EDGE];
            wcause[W_LEVEL] = ev.lvl[P_LEVEL];
            wcause[W_CUR] = ev.lvl[P_CUR];
            wcause[W_SPI] = go && cmd == CMD_RESUME;
            wcause[W_TIMER] = wake_timer_done & cur_reg.saved.wtimer;
            wake_now = |wcause;
         end
         ST_STANDBY: begin
            // supplies were off, so restart through sequencing
            if (wake_pin || (go && cmd == CMD_RESUME)) begin
               cur_next.st = ST_POWERDOWN;
            end
         end
         ST_FAILSAFE: begin
            cur_next.st = ST_FAILSAFE;
         end
         default: begin
            cur_next.st = ST_FAILSAFE;
         end
      endcase
      if (wake_now) begin
         cur_next.st = ST_WAKE;
         // a selftest entry has just saved the live set in this cycle
         cur_next.live = cur_next.saved;
         cur_next.irq_cnt = IRQ_LOAD;
         cur_next.take = 1'b1;
         cur_next.cause = wcause;
      end
      if (severe_fail && cur_reg.st != ST_POWERDOWN) begin
         cur_next.st = ST_FAILSAFE;
         cur_next.irq_cnt = '0;
      end

      // outputs follow the next state so they switch with it
      up = cur_next.st inside {ST_INIT, ST_NORMAL, ST_TO_SLEEP,
         ST_SLEEP, ST_WAKE};
      sel_live = cur_next.st inside {ST_INIT, ST_NORMAL, ST_WAKE};
      sel_slp = cur_next.st inside {ST_TO_SLEEP, ST_SLEEP};
      c = sel_live ? cur_next.live : (sel_slp ? cur_next.slp : '0);
      cur_next.o.mcu = up;
      cur_next.o.pre = up;
      cur_next.o.boost = up & cur_next.boost_strap & ev.lvl[P_VLOW];
      cur_next.o.core = up & cur_next.core_strap;
      cur_next.o.comm = c.comm;
      cur_next.o.ref_en = c.ref_en;
      cur_next.o.trk = c.tracker;
      cur_next.o.stby = (cur_next.st == ST_STANDBY) ?
         cur_next.saved.standby : c.standby;
      cur_next.o.wdog = c.wdog;
      cur_next.o.hb = c.hb;
      cur_next.o.err = c.err;
      cur_next.o.wtim = (cur_next.st inside {ST_SLEEP, ST_STANDBY}) &
         cur_next.saved.wtimer;
      cur_next.o.rst_n = up;
      cur_next.o.safe = cur_next.st == ST_NORMAL;
      cur_next.o.irq = cur_next.irq_cnt != '0;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_reg <= '0;
      end else begin
         cur_reg <= cur_next;
      end
   end

   assign standby_supply_en = cur_reg.o.stby;
   assign mcu_supply_en = cur_reg.o.mcu;
   assign comm_supply_en = cur_reg.o.comm;
   assign ref_supply_en = cur_reg.o.ref_en;
   assign sensor_tracker_en = cur_reg.o.trk;
   assign pre_converter_en = cur_reg.o.pre;
   assign boost_en = cur_reg.o.boost;
   assign core_supply_en = cur_reg.o.core;
   assign wake_timer_en = cur_reg.o.wtim;
   assign window_watchdog_en = cur_reg.o.wdog;
   assign heartbeat_watchdog_en = cur_reg.o.hb;
   assign fault_monitor_en = cur_reg.o.err;
   assign sys_reset_pin_n = cur_reg.o.rst_n;
   assign safe_state_control = cur_reg.o.safe;
   assign safe_state_out_a = cur_reg.o.safe;
   assign safe_state_out_b = cur_reg.o.safe;
   assign irq = cur_reg.o.irq;
   assign wake_source_flags = ev.flags;
   assign op_state = cur_reg.st;
endmodule // pm_sequencer

// *** verification/pm_sequencer_chk.sv ***
module pm_sequencer_chk
   import pm_seq_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // watched inputs
   input wire logic spi_select_n,
   input wire logic monitors_serviced,
   input wire logic severe_fail,
   // watched outputs
   input wire logic mcu_supply_en,
   input wire logic pre_converter_en,
   input wire logic wake_timer_en,
   input wire logic fault_monitor_en,
   input wire logic sys_reset_pin_n,
   input wire logic safe_state_control,
   input wire logic safe_state_out_a,
   input wire logic safe_state_out_b,
   input wire logic irq,
   input wire pm_seq_pkg::pm_state_e op_state
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic wk;
   logic fs;
   logic safe;
   assign wk = op_state == ST_WAKE;
   assign fs = op_state == ST_FAILSAFE;
   assign safe = safe_state_out_a | safe_state_out_b | safe_state_control;

   wake_safe_low_a: assert property (wk |-> !safe)
      else $error("safe output high in wake");
   wake_reset_high_a: assert property (wk |-> sys_reset_pin_n)
      else $error("reset asserted in wake");
   wake_timer_off_a: assert property (wk |-> !wake_timer_en)
      else $error("wake timer on in wake");
   wake_supply_on_a: assert property (
      wk |-> mcu_supply_en && pre_converter_en)
      else $error("supply off in wake");
   // pulse is 25 cycles, eight suffice to catch a missing one
   wake_irq_pulse_a: assert property (
      !wk ##1 wk |-> irq [*8])
      else $error("no interrupt on wake entry");
   fail_entry_a: assert property (
      severe_fail && op_state != ST_POWERDOWN |=> fs)
      else $error("failsafe not entered");
   fail_quiet_a: assert property (
      fs |-> !safe && !sys_reset_pin_n && !mcu_supply_en
      && !pre_converter_en && !fault_monitor_en && !wake_timer_en)
      else $error("output on in failsafe");
   fail_held_a: assert property (fs |=> fs)
      else $error("failsafe left without reset");
   safe_pair_a: assert property (
      safe_state_out_a == safe_state_out_b
      && safe_state_control == safe_state_out_a)
      else $error("safe outputs differ");
   // the pin must really have risen, two sync stages before the take
   normal_gate_a: assert property (
      op_state == ST_INIT ##1 op_state == ST_NORMAL
      |-> $past(spi_select_n, 3) && !$past(spi_select_n, 4)
      && $past(monitors_serviced, 2))
      else $error("normal entered without request");

   cover property (!wk ##1 wk);
   cover property (!fs ##1 fs);
   cover property (op_state == ST_INIT ##1 op_state == ST_NORMAL);
endmodule // pm_sequencer_chk

bind pm_sequencer pm_sequencer_chk u_chk (
   .core_clk(core_clk),
   .rst(rst),
   .spi_select_n(spi_select_n),
   .monitors_serviced(monitors_serviced),
   .severe_fail(severe_fail),
   .mcu_supply_en(mcu_supply_en),
   .pre_converter_en(pre_converter_en),
   .wake_timer_en(wake_timer_en),
   .fault_monitor_en(fault_monitor_en),
   .sys_reset_pin_n(sys_reset_pin_n),
   .safe_state_control(safe_state_control),
   .safe_state_out_a(safe_state_out_a),
   .safe_state_out_b(safe_state_out_b),
   .irq(irq),
   .op_state(op_state)
);

// *** verification/host_model.sv ***
module host_model (
   // clock
   input wire logic core_clk,
   // frame and command fields
   output logic spi_select_n,
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic [7:0] cmd_data,
   output logic monitors_serviced
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      spi_select_n = 1'b1;
      cmd_valid = 1'b0;
      cmd_code = 3'h0;
      cmd_data = 8'h00;
      monitors_serviced = 1'b0;
   end

   // len sets frame length: 16 prompt, 256 slow
   task automatic send(logic [2:0] c, logic [7:0] d, int len);
      @(posedge core_clk);
      spi_select_n <= 1'b0;
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_data <= d;
      repeat (len) @(posedge core_clk);
      spi_select_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      cmd_valid <= 1'b0;
      // released fields flip so stale values cannot pass
      cmd_code <= ~c;
      cmd_data <= ~d;
   endtask

   task automatic serve;
      @(posedge core_clk);
      monitors_serviced <= 1'b1;
      repeat (15000) @(posedge core_clk);
   endtask
endmodule // host_model

// *** verification/tb.sv ***
module tb
   import pm_seq_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, edge_wake_in, level_rouse_in, mcu_current_threshold;
   logic supply_rise_threshold, core_seq_pin, boost_select_pin, vin_low;
   logic analog_selftest, wake_timer_done, severe_fail, wake_flags_clr;
   logic spi_select_n, cmd_valid, monitors_serviced;
   logic [2:0] cmd_code;
   logic [7:0] cmd_data;
   wire [15:0] o;
   wire [4:0] wf;
   wire irq;
   pm_state_e st;
   int seed, cfg, bad_count, checks_done;
   logic [31:0] r;

   host_model u_host (.core_clk(core_clk), .spi_select_n(spi_select_n),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
      .monitors_serviced(monitors_serviced));

   pm_sequencer #(.TR_DEL_CYCLES(20)) u_dut (.core_clk(core_clk), .rst(rst),
      .spi_select_n(spi_select_n), .edge_wake_in(edge_wake_in),
      .level_rouse_in(level_rouse_in),
      .mcu_current_threshold(mcu_current_threshold),
      .supply_rise_threshold(supply_rise_threshold),
      .core_seq_pin(core_seq_pin), .boost_select_pin(boost_select_pin),
      .vin_low(vin_low), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_data(cmd_data), .monitors_serviced(monitors_serviced),
      .analog_selftest(analog_selftest), .wake_timer_done(wake_timer_done),
      .severe_fail(severe_fail), .wake_flags_clr(wake_flags_clr),
      .standby_supply_en(o[0]), .comm_supply_en(o[1]), .ref_supply_en(o[2]),
      .sensor_tracker_en(o[3]), .window_watchdog_en(o[4]),
      .heartbeat_watchdog_en(o[5]), .fault_monitor_en(o[6]),
      .wake_timer_en(o[7]), .mcu_supply_en(o[8]), .pre_converter_en(o[9]),
      .boost_en(o[10]), .core_supply_en(o[11]), .sys_reset_pin_n(o[12]),
      .safe_state_control(o[13]), .safe_state_out_a(o[14]),
      .safe_state_out_b(o[15]), .irq(irq), .wake_source_flags(wf),
      .op_state(st));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // wake outputs: live config, timer off, supplies and straps
   function automatic logic [15:0] wexp(logic [7:0] c);
      return {4'h1, core_seq_pin, boost_select_pin & vin_low, 3'b110, c[6:0]};
   endfunction

   task automatic chk(logic [15:0] g, logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_st(pm_state_e e);
      checks_done++;
      if (st !== e) begin
         bad_count++;
         $display("Error %0t state %0h exp %0h", $time, st, e);
      end
   endtask

   task automatic wait_st(pm_state_e e);
      @(negedge core_clk);
      for (int n = 0; n < 60 && st !== e; n++) @(negedge core_clk);
      chk_st(e);
   endtask

   task automatic go(pm_cmd_e c, logic [7:0] d, pm_state_e e);
      u_host.send(c, d, 16);
      wait_st(e);
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      chk_st(ST_POWERDOWN);
      chk(o, 16'h0000);
      @(posedge core_clk);
      rst <= 1'b0;
      wait_st(ST_INIT);
   endtask

   task automatic stop_test;
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #300_000;
      bad_count++;
      stop_test();
   end

   initial begin
      seed = 32'hbec2_dbb9;
      r = $random(seed);
      {rst, edge_wake_in, level_rouse_in, mcu_current_threshold} = 4'b1000;
      {analog_selftest, severe_fail, wake_flags_clr} = 3'b000;
      {supply_rise_threshold, wake_timer_done} = 2'b10;
      {core_seq_pin, boost_select_pin, vin_low} = r[2:0];
      do_reset();
      go(CMD_GO_NORMAL, 8'h00, ST_INIT);
      u_host.serve();
      go(CMD_GO_NORMAL, 8'h00, ST_NORMAL);
      chk(o, wexp(CFG_RESET) | 16'he000);
      cfg = $random(seed);
      u_host.send(CMD_SET_CFG, cfg[7:0], 256);
      go(CMD_GO_SLEEP, 8'h80, ST_TO_SLEEP);
      chk(o & 16'he000, 16'h0000);
      wait_st(ST_SLEEP);
      go(CMD_RESUME, 8'h00, ST_WAKE);
      @(negedge core_clk);
      chk(o, wexp(cfg[7:0]));
      chk({11'h000, wf}, 16'h0008);
      chk({15'h0000, irq}, 16'h0001);
      cfg = $random(seed);
      go(CMD_SET_CFG, cfg[7:0], ST_WAKE);
      chk(o, wexp(cfg[7:0]));
      // the wake interrupt is a pulse and has ended by now
      chk({15'h0000, irq}, 16'h0000);
      // edge pin during transition, level and current from sleep
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         wake_flags_clr <= 1'b1;
         go(CMD_GO_SLEEP, 8'h80, ST_TO_SLEEP);
         @(posedge core_clk);
         wake_flags_clr <= 1'b0;
         if (i != 0) wait_st(ST_SLEEP);
         @(posedge core_clk);
         {mcu_current_threshold, level_rouse_in, edge_wake_in} <= 3'(1 << i);
         wait_st(ST_WAKE);
         @(negedge core_clk);
         chk({11'h000, wf}, 16'(1 << i));
         @(posedge core_clk);
         {mcu_current_threshold, level_rouse_in, edge_wake_in} <= 3'b000;
      end
      go(CMD_GO_NORMAL, 8'h00, ST_NORMAL);
      cfg = $random(seed);
      go(CMD_SET_CFG, cfg[7:0], ST_NORMAL);
      @(posedge core_clk);
      analog_selftest <= 1'b1;
      @(posedge core_clk);
      analog_selftest <= 1'b0;
      wait_st(ST_WAKE);
      // selftest wake keeps the normal set written just before
      chk(o, wexp(cfg[7:0]));
      chk({15'h0000, irq}, 16'h0001);
      go(CMD_GO_STANDBY, 8'h00, ST_STANDBY);
      go(CMD_RESUME, 8'h00, ST_INIT);
      @(posedge core_clk);
      severe_fail <= 1'b1;
      wait_st(ST_FAILSAFE);
      @(negedge core_clk);
      chk(o, 16'h0000);
      go(CMD_RESUME, 8'h00, ST_FAILSAFE);
      @(posedge core_clk);
      severe_fail <= 1'b0;
      do_reset();
      stop_test();
   end
endmodule // tb
